//--- watchdog_pkg.sv
// constants, mode codes, register map and bus carriers of the watchdog timer
// assumes a single 100 MHz clock and a classic wishbone master outside
//
// Contract
// - counter is cleared when the device enters sleep, in every mode
// - if still enabled in sleep, counting restarts from zero after that clear
// - counter is cleared again on leaving sleep
// - leaving sleep on a crystal clock holds the counter at zero until startup ends
// - expiry during sleep wakes the device instead of resetting it
// - wake by expiry updates timeout and powerdown status flags; here wake sets only the timeout flag, powerdown keeps its sleep-entry value
// - in software mode the counter stays cleared while soft enable is zero
// - in off-in-sleep mode, sleep entry clears and counting stops during sleep
// - oscillator divider changes never touch the counter
// - control holds period select in bits 5..1, enable in bit 0, 7..6 read zero
// - select code n up to 10010 gives a prescale of 32 times two to n
// - select codes 10011 to 11111 give the minimum 1:32 prescale
// - period select resets to 01011, prescale 1:65536
// - in software mode, enable one runs the watchdog, zero stops it
// - in modes 00 and 1x the soft enable bit is ignored
// - time base is the 31 kHz internal oscillator, independent of system clock; here it is clk_i divided by TB_DIV
// - expiry while awake and active generates a device reset
// - firmware clears within the period; the clear instruction zeroes the counter
// - mode 11 keeps the watchdog active always, sleep included

package watchdog_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TB_PERIOD_NS = 32258;
	localparam int TB_DIV = TB_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TB_DIV_W = 12;

	// ----------------------------------------------------------------
	// counter and period select
	// ----------------------------------------------------------------
	localparam int CNT_W = 24;
	localparam int SEL_W = 5;
	localparam logic [SEL_W-1:0] SEL_MAX = 5'h12;
	localparam logic [SEL_W-1:0] SEL_RESET = 5'h0b;
	localparam logic [CNT_W-1:0] MIN_PRESCALE = 24'h000020;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

	// ----------------------------------------------------------------
	// configuration mode codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_SOFT = 2'h1,
		MODE_NSLEEP = 2'h2,
		MODE_ON = 2'h3
	} wdt_mode_t;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] CTRL_OFF = 8'h00;
	localparam logic [ADR_W-1:0] STATUS_OFF = 8'h04;
	localparam logic [ADR_W-1:0] COUNT_OFF = 8'h08;
	localparam logic [ADR_W-1:0] WORD_MASK = 8'hfc;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam int CTRL_SEL_MSB = 5;
	localparam int STAT_TO_BIT = 0;
	localparam int STAT_PD_BIT = 1;
	localparam logic [31:0] DATA_ZERO = 32'h00000000;

	// ----------------------------------------------------------------
	// bus carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_W-1:0] adr;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;

	// ----------------------------------------------------------------
	// prescale from select code
	// ----------------------------------------------------------------
	function automatic logic [CNT_W-1:0] prescale_limit(input logic [SEL_W-1:0] code);
		logic [CNT_W-1:0] lim;
		lim = MIN_PRESCALE;
		if (code <= SEL_MAX) begin
			lim = MIN_PRESCALE << code;
		end
		return lim;
	endfunction : prescale_limit

endpackage : watchdog_pkg

//--- tick_divider.sv
// free-running divider giving a one-cycle enable at the watchdog time-base rate
// assumes the system clock and a synchronous active-high reset

`timescale 1ns/1ps

module tick_divider #(
	parameter int DIV = watchdog_pkg::TB_DIV,
	parameter int W = watchdog_pkg::TB_DIV_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// time-base enable
	output logic tick_o
);

	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam logic [W-1:0] ONE = W'(1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} div_state_t;

	div_state_t s_reg;
	div_state_t s_next;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.cnt == LAST) begin
			s_next.cnt = '0;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + ONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick_o = s_reg.tick;

endmodule : tick_divider

//--- watchdog_timer.sv
// watchdog timer with sleep handling and a wishbone register port
// assumes sleep, startup and clear-instruction inputs synchronous to clk_i
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.

`timescale 1ns/1ps

module watchdog_timer #(
	// time-base divide ratio, at most 2**TB_DIV_W, shrinkable for short runs
	parameter int TICK_DIV = watchdog_pkg::TB_DIV
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register bus
	input wire watchdog_pkg::wb_req_t wb_i,
	output watchdog_pkg::wb_rsp_t wb_o,
	// configuration and core status
	input wire watchdog_pkg::wdt_mode_t watchdog_mode_config_i,
	input wire logic sleep_i,
	input wire logic crystal_clock_i,
	input wire logic osc_startup_timer_running_i,
	input wire logic clear_watchdog_instr_i,
	input wire logic osc_fail_i,
	input wire logic [2:0] internal_osc_freq_select_i,
	// events and flags
	output logic device_reset_o,
	output logic wake_o,
	output logic timeout_flag_o,
	output logic powerdown_flag_o
);

	typedef struct packed {
		logic [watchdog_pkg::CNT_W-1:0] count;
		logic [watchdog_pkg::SEL_W-1:0] period_select;
		logic soft_enable;
		logic timeout_flag;
		logic powerdown_flag;
		logic sleep_d;
		logic ost_hold;
		logic reset_pulse;
		logic wake_pulse;
		logic ack;
		logic [31:0] rdat;
	} wdt_state_t;

	wdt_state_t s_reg;
	wdt_state_t s_next;
	logic tb_tick;

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	tick_divider #(
		.DIV(TICK_DIV),
		.W(watchdog_pkg::TB_DIV_W)
	) tick_divider_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(tb_tick)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic sleep_enter;
	logic sleep_exit;
	logic active;
	logic clear_cnt;
	logic expire;
	logic [watchdog_pkg::CNT_W-1:0] limit;
	logic bus_req;
	logic wr_ctrl;
	logic wr_stat;
	logic clr_to;
	logic clr_pd;
	logic [watchdog_pkg::ADR_W-1:0] word_adr;

	always_comb begin
		s_next = s_reg;
		sleep_enter = sleep_i & ~s_reg.sleep_d;
		sleep_exit = ~sleep_i & s_reg.sleep_d;
		s_next.sleep_d = sleep_i;

		// which modes run the counter
		unique case (watchdog_mode_config_i)
			watchdog_pkg::MODE_ON: active = 1'b1;
			watchdog_pkg::MODE_NSLEEP: active = ~sleep_i;
			watchdog_pkg::MODE_SOFT: active = s_reg.soft_enable;
			watchdog_pkg::MODE_OFF: active = 1'b0;
			default: active = 1'b0;
		endcase

		// startup hold after leaving sleep on a crystal clock
		if (sleep_exit & crystal_clock_i) begin
			s_next.ost_hold = 1'b1;
		end else if (~osc_startup_timer_running_i) begin
			s_next.ost_hold = 1'b0;
		end

		// divider select is deliberately not a clear term
		clear_cnt = ~active
			| clear_watchdog_instr_i
			| osc_fail_i
			| sleep_enter
			| sleep_exit
			| s_reg.ost_hold
			| osc_startup_timer_running_i;

		limit = watchdog_pkg::prescale_limit(s_reg.period_select);
		// at or past the limit: a shorter period picked mid-count must not wrap first
		expire = ~clear_cnt & tb_tick & (s_reg.count >= (limit - watchdog_pkg::CNT_ONE));

		if (clear_cnt | expire) begin
			s_next.count = watchdog_pkg::CNT_ZERO;
		end else if (tb_tick) begin
			s_next.count = s_reg.count + watchdog_pkg::CNT_ONE;
		end

		// expiry action depends on sleep state
		s_next.reset_pulse = expire & ~sleep_i;
		s_next.wake_pulse = expire & sleep_i;

		// register bus decode
		bus_req = wb_i.cyc & wb_i.stb & ~s_reg.ack;
		word_adr = wb_i.adr & watchdog_pkg::WORD_MASK;
		wr_ctrl = bus_req & wb_i.we & wb_i.sel[0] & (word_adr == watchdog_pkg::CTRL_OFF);
		wr_stat = bus_req & wb_i.we & wb_i.sel[0] & (word_adr == watchdog_pkg::STATUS_OFF);
		s_next.ack = bus_req;

		if (wr_ctrl) begin
			s_next.period_select =
				wb_i.dat[watchdog_pkg::CTRL_SEL_MSB:watchdog_pkg::CTRL_SEL_LSB];
			s_next.soft_enable = wb_i.dat[watchdog_pkg::CTRL_EN_BIT];
		end

		// flags: set wins over any clear in the same cycle
		clr_to = clear_watchdog_instr_i | (wr_stat & wb_i.dat[watchdog_pkg::STAT_TO_BIT]);
		clr_pd = clear_watchdog_instr_i | (wr_stat & wb_i.dat[watchdog_pkg::STAT_PD_BIT]);
		if (expire) begin
			s_next.timeout_flag = 1'b1;
		end else if (clr_to) begin
			s_next.timeout_flag = 1'b0;
		end
		if (sleep_enter) begin
			s_next.powerdown_flag = 1'b1;
		end else if (clr_pd) begin
			s_next.powerdown_flag = 1'b0;
		end

		// read data, unmapped words read zero
		s_next.rdat = watchdog_pkg::DATA_ZERO;
		if (bus_req & ~wb_i.we) begin
			unique case (word_adr)
				watchdog_pkg::CTRL_OFF: begin
					s_next.rdat[watchdog_pkg::CTRL_SEL_MSB:watchdog_pkg::CTRL_SEL_LSB] =
						s_reg.period_select;
					s_next.rdat[watchdog_pkg::CTRL_EN_BIT] = s_reg.soft_enable;
				end
				watchdog_pkg::STATUS_OFF: begin
					s_next.rdat[watchdog_pkg::STAT_TO_BIT] = s_reg.timeout_flag;
					s_next.rdat[watchdog_pkg::STAT_PD_BIT] = s_reg.powerdown_flag;
				end
				watchdog_pkg::COUNT_OFF: begin
					s_next.rdat[watchdog_pkg::CNT_W-1:0] = s_reg.count;
				end
				default: begin
					s_next.rdat = watchdog_pkg::DATA_ZERO;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.period_select <= watchdog_pkg::SEL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_o.ack = s_reg.ack;
	assign wb_o.dat = s_reg.rdat;
	assign device_reset_o = s_reg.reset_pulse;
	assign wake_o = s_reg.wake_pulse;
	assign timeout_flag_o = s_reg.timeout_flag;
	assign powerdown_flag_o = s_reg.powerdown_flag;

endmodule : watchdog_timer

//--- watchdog_timer_asserts.sv
// port checker for the watchdog timer
// bound to watchdog_timer, sees only its ports
`timescale 1ns/1ps
module watchdog_timer_asserts (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// observed ports
	input wire watchdog_pkg::wb_req_t wb_i,
	input wire watchdog_pkg::wb_rsp_t wb_o,
	input wire watchdog_pkg::wdt_mode_t watchdog_mode_config_i,
	input wire logic sleep_i,
	input wire logic clear_watchdog_instr_i,
	input wire logic device_reset_o,
	input wire logic wake_o,
	input wire logic timeout_flag_o,
	input wire logic powerdown_flag_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_follows_req: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
		else $error("request not acknowledged");
	a_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("ack longer than one cycle");
	a_reset_when_awake: assert property (device_reset_o |-> !$past(sleep_i) && timeout_flag_o)
		else $error("device reset while asleep");
	a_wake_when_asleep: assert property (wake_o |-> $past(sleep_i) && timeout_flag_o)
		else $error("wake without sleep");
	a_wake_pulse: assert property (wake_o |=> !wake_o)
		else $error("wake longer than one cycle");
	a_sleep_flag: assert property ($rose(sleep_i) |-> ##[1:2] powerdown_flag_o)
		else $error("powerdown flag not set");
	a_off_quiet: assert property ((watchdog_mode_config_i == watchdog_pkg::MODE_OFF) [*2]
		|=> !(device_reset_o || wake_o))
		else $error("expiry while off");
	a_clear_quiet: assert property (clear_watchdog_instr_i |=> !(device_reset_o || wake_o))
		else $error("expiry despite clear");
	a_entry_quiet: assert property ($rose(sleep_i) |=> !wake_o)
		else $error("expiry at sleep entry");
endmodule : watchdog_timer_asserts

bind watchdog_timer watchdog_timer_asserts watchdog_timer_asserts_i (.clk_i, .rst_i, .wb_i, .wb_o,
	.watchdog_mode_config_i, .sleep_i, .clear_watchdog_instr_i, .device_reset_o, .wake_o,
	.timeout_flag_o, .powerdown_flag_o);

//--- test_watchdog_timer.sv
// self-checking bench for the watchdog timer
// shrinks the design's time-base divider to keep the run short
`timescale 1ns/1ps
module test_watchdog_timer;
	localparam int TICK = 20;
	logic clk_i, rst_i, sleep, xtal, ost_run, clr, osc_fail, dev_rst, wake, to_flag, pd_flag;
	logic [2:0] freq_sel;
	logic [31:0] rd, cnt;
	watchdog_pkg::wb_req_t wb_req;
	watchdog_pkg::wb_rsp_t wb_rsp;
	watchdog_pkg::wdt_mode_t mode;
	int n_mismatch, n_compared, cycles, n;

	watchdog_timer #(.TICK_DIV(TICK)) watchdog_timer_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_i(wb_req), .wb_o(wb_rsp),
		.watchdog_mode_config_i(mode), .sleep_i(sleep), .crystal_clock_i(xtal),
		.osc_startup_timer_running_i(ost_run), .clear_watchdog_instr_i(clr),
		.osc_fail_i(osc_fail), .internal_osc_freq_select_i(freq_sel),
		.device_reset_o(dev_rst), .wake_o(wake), .timeout_flag_o(to_flag),
		.powerdown_flag_o(pd_flag));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge clk_i);
		wb_req <= '{1'b1, 1'b1, we, 4'hf, adr, wd};
		do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
		rd = wb_rsp.dat;
		wb_req <= '0;
	endtask : wb

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 10000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	initial begin
		{rst_i, sleep, xtal, ost_run, clr, osc_fail, freq_sel} = 9'h100;
		wb_req = '0;
		mode = watchdog_pkg::MODE_SOFT;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, watchdog_pkg::CTRL_OFF, 0); chk("ctrl reset", 32'h16, rd);
		wb(0, 8'h0c, 0); chk("unmapped", 32'h0, rd);
		wb(1, watchdog_pkg::CTRL_OFF, 32'hff);
		wb(0, watchdog_pkg::CTRL_OFF, 0); chk("ctrl bits", 32'h3f, rd);
		wb(1, watchdog_pkg::CTRL_OFF, 32'h26);
		repeat (TICK + 10) @(posedge clk_i);
		wb(0, watchdog_pkg::COUNT_OFF, 0); chk("count soft off", 32'h0, rd);
		wb(1, watchdog_pkg::CTRL_OFF, 32'h27);
		wb(0, watchdog_pkg::COUNT_OFF, 0);
		cnt = rd;
		freq_sel <= 3'h5;
		repeat (TICK - 3) @(posedge clk_i);
		wb(0, watchdog_pkg::COUNT_OFF, 0); chk("count step", cnt + 1, rd);
		repeat (4 * TICK) @(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		wb(0, watchdog_pkg::COUNT_OFF, 0); chk("count clear", 32'h0, {rd[31:1], 1'b0});
		// off in sleep: powerdown flag set, timeout flag and count held at zero
		mode <= watchdog_pkg::MODE_NSLEEP;
		wb(1, watchdog_pkg::STATUS_OFF, 32'h3);
		sleep <= 1'b1;
		repeat (TICK + 10) @(posedge clk_i);
		wb(0, watchdog_pkg::STATUS_OFF, 0); chk("status sleep", 32'h2, rd);
		wb(0, watchdog_pkg::COUNT_OFF, 0); chk("count sleep", 32'h0, rd);
		// crystal exit holds count until startup ends
		{xtal, ost_run} <= 2'h3;
		sleep <= 1'b0;
		repeat (TICK + 10) @(posedge clk_i);
		wb(0, watchdog_pkg::COUNT_OFF, 0); chk("count startup", 32'h0, rd);
		{xtal, ost_run} <= 2'h0;
		// always on, reserved select: wake after 32 ticks of sleep
		mode <= watchdog_pkg::MODE_ON;
		wb(1, watchdog_pkg::STATUS_OFF, 32'h3);
		sleep <= 1'b1;
		n = 0;
		while (wake !== 1'b1 && n < 33 * TICK) begin
			@(posedge clk_i);
			n++;
		end
		chk("wake time", 32'h1, {31'h0, n > 31 * TICK + 1 && n <= 32 * TICK + 2});
		wb(0, watchdog_pkg::STATUS_OFF, 0); chk("status wake", 32'h3, rd);
		// awake expiry at select code 00001, soft enable ignored in mode 11
		wb(1, watchdog_pkg::STATUS_OFF, 32'h3);
		sleep <= 1'b0;
		wb(1, watchdog_pkg::CTRL_OFF, 32'h2);
		n = 0;
		while (dev_rst !== 1'b1 && n < 65 * TICK) begin
			@(posedge clk_i);
			n++;
		end
		chk("reset time", 32'h1, {31'h0, n > 63 * TICK - 2 && n < 64 * TICK + 2});
		chk("timeout flag", 32'h1, {31'h0, to_flag});
		chk("powerdown flag", 32'h0, {31'h0, pd_flag});
		// always off: soft enable ignored, no expiry at all
		mode <= watchdog_pkg::MODE_OFF;
		wb(1, watchdog_pkg::CTRL_OFF, 32'h3);
		n = 0;
		repeat (66 * TICK) begin
			@(posedge clk_i);
			n += int'(dev_rst !== 1'b0);
		end
		chk("resets while off", 32'h0, n);
		wb(0, watchdog_pkg::COUNT_OFF, 0); chk("count off", 32'h0, rd);
		end_of_test();
	end
endmodule : test_watchdog_timer
